// ==== core/fue_buf2.sv ====
`timescale 1ns/100ps
// Two-entry skid buffer: receiver stall loses no word, full rate when flowing
module fue_buf2 (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [7:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  typedef struct packed {
    logic [7:0] d0;
    logic [7:0] d1;
    logic [1:0] cnt;
  } fue_buf_type;
  fue_buf_type s_r;
  fue_buf_type s_nxt;
  logic push;
  logic pop;

  // Handshakes are combinational from the held count
  assign in_ready = (s_r.cnt != 2'h2);
  assign out_valid = (s_r.cnt != 2'h0);
  assign out_data = s_r.d0;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Entry 0 is always the head; entry 1 shifts down on pop
  always_comb begin
    s_nxt = s_r;
    if (pop) begin
      s_nxt.d0 = s_r.d1;
    end
    if (push) begin
      if ((s_r.cnt == 2'h0) || (s_r.cnt == 2'h1 && pop)) begin
        s_nxt.d0 = in_data;
      end else begin
        s_nxt.d1 = in_data;
      end
    end
    s_nxt.cnt = s_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end
endmodule

// ==== core/fue_core.sv ====
`timescale 1ns/100ps
`include "fue_params.svh"
module fue_core (
  input wire logic clk,
  input wire logic reset_n,
  // Command bytes from the SPI byte transport
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic rx_ready,
  // Response bytes towards the SPI byte transport
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  // Firmware status and busy line
  input wire logic fw_valid,
  output logic busy,
  // Flash write port
  output logic [31:0] flash_addr,
  output logic [7:0] flash_wdata,
  output logic flash_wr,
  input wire logic flash_ready,
  output logic flash_serial,
  // Flash erase request
  output logic [31:0] erase_begin,
  output logic [31:0] erase_end,
  output logic erase_start,
  input wire logic erase_done
);
  import fue_pkg::*;

  typedef struct packed {
    fue_state_type st;
    logic [7:0] op;
    logic [7:0] grp;
    logic [7:0] tgt;
    logic [7:0] pos;
    logic [1:0] hidx;
    logic [15:0] len;
    logic [15:0] cnt;
    logic [7:0] sum;
    logic [31:0] addr;
    logic [31:0] ebeg;
    logic [31:0] eend;
    logic [15:0] crc;
    logic [31:0] npkt;
    logic [7:0] err0;
    logic [7:0] err1;
    logic in_xfer;
    logic xfer_tgt;
    fue_cmd_type cmd;
    logic wr;
    logic [7:0] wdata;
    logic serial;
    logic estart;
    logic ewait;
    logic [3:0] ridx;
    logic [7:0] rsum;
    logic [7:0] txd;
    logic txv;
  } fue_core_type;

  fue_core_type s_r;
  fue_core_type s_nxt;
  logic [7:0] rd;
  logic rv;
  logic rr;
  logic take;
  logic [7:0] rlen;
  logic [7:0] rbyte;

  // CRC16 step over one byte, used for written data
  function automatic logic [15:0] crc16_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] x;
    x = c ^ {d, 8'h00};
    for (int i = 0; i < 8; i++) begin
      x = x[15] ? ((x << 1) ^ `FUE_CRC_POLY) : (x << 1);
    end
    return x;
  endfunction

  // Skid buffer keeps incoming bytes while flash writes back-pressure us
  fue_buf2 fue_buf2_inst (
    .clk(clk),
    .reset_n(reset_n),
    .in_data(rx_data),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .out_data(rd),
    .out_valid(rv),
    .out_ready(rr)
  );

  // Stall the parser while a flash write is pending or response is going out.
  // The checksum byte waits for the last write, else it would be popped unseen;
  // nothing is taken while the last reply byte drains, so no new header is lost.
  assign rr = (s_r.st != FUE_EXEC) && (s_r.st != FUE_RESP) && (s_r.st != FUE_SKIP)
              && !(s_r.wr && (!flash_ready || (s_r.st == FUE_CSUM)));
  assign take = rv && rr;
  // Short response when any err0 fault (checksum, header, length or sequence) made payload meaningless
  assign rlen = (s_r.err0 != 8'h00) ? `FUE_ERR_LEN : `FUE_RESP_LEN;

  // Response byte selector by index: header, length, payload, checksum
  always_comb begin
    unique case (s_r.ridx)
      4'h0: rbyte = `FUE_OP_WRITE_RESPONSE_OPCODE;
      4'h1: rbyte = s_r.grp;
      4'h2: rbyte = 8'h00;
      4'h3: rbyte = 8'h00;
      4'h4: rbyte = rlen;
      4'h5: rbyte = 8'h00;
      4'h6: rbyte = s_r.err0;
      4'h7: rbyte = s_r.err1;
      4'h8: rbyte = s_r.crc[7:0];
      4'h9: rbyte = s_r.crc[15:8];
      4'hA: rbyte = s_r.npkt[7:0];
      4'hB: rbyte = s_r.npkt[15:8];
      4'hC: rbyte = s_r.npkt[23:16];
      4'hD: rbyte = s_r.npkt[31:24];
      default: rbyte = s_r.rsum;
    endcase
  end

  // Main packet parser
  always_comb begin
    s_nxt = s_r;
    s_nxt.estart = 1'b0;
    if (s_r.wr && flash_ready) begin
      s_nxt.wr = 1'b0;
      s_nxt.addr = s_r.addr + 32'h0000_0001;
    end
    unique case (s_r.st)
      FUE_HDR: begin
        if (take) begin
          // Header bytes in fixed order
          unique case (s_r.hidx)
            2'h0: s_nxt.op = rd;
            2'h1: s_nxt.grp = rd;
            2'h2: s_nxt.tgt = rd;
            default: s_nxt.pos = rd;
          endcase
          s_nxt.hidx = s_r.hidx + 2'h1;
          if (s_r.hidx == 2'h3) begin
            s_nxt.st = FUE_LENL;
          end
        end
      end
      FUE_LENL: begin
        if (take) begin
          s_nxt.len[7:0] = rd;
          s_nxt.sum = rd;
          s_nxt.st = FUE_LENH;
        end
      end
      FUE_LENH: begin
        if (take) begin
          s_nxt.len[15:8] = rd;
          s_nxt.sum = s_r.sum + rd;
          s_nxt.cnt = 16'h0000;
          s_nxt.cmd = FUE_CMD_NONE;
          // A packet outside a transfer starts a clean report; old faults must not leak in
          if (!s_r.in_xfer) begin
            s_nxt.err0 = 8'h00;
            s_nxt.err1 = 8'h00;
          end
          if (s_r.op != `FUE_OP_WRITE) begin
            s_nxt.err0 = s_nxt.err0 | `FUE_ERR_HDR;
          end else if (s_r.grp == `FUE_FG_UPDATE) begin
            s_nxt.cmd = FUE_CMD_WRITE;
            s_nxt.serial = (s_r.tgt == `FUE_TGT_SERIAL);
            if (s_r.tgt != `FUE_TGT_SERIAL && s_r.tgt != `FUE_TGT_PARALLEL) begin
              s_nxt.err0 = s_nxt.err0 | `FUE_ERR_HDR;
            end
            if (s_r.tgt == `FUE_TGT_SERIAL && !fw_valid) begin
              s_nxt.err1 = s_nxt.err1 | `FUE_ERR_FW;
            end
            // Position byte sets expected length and sequencing
            if (s_r.pos == `FUE_POS_FIRST) begin
              s_nxt.in_xfer = 1'b1;
              s_nxt.xfer_tgt = (s_r.tgt == `FUE_TGT_SERIAL);
              s_nxt.npkt = 32'h0000_0000;
              s_nxt.crc = `FUE_CRC_INIT;
              s_nxt.err0 = 8'h00;
              s_nxt.err1 = (s_r.tgt == `FUE_TGT_SERIAL && !fw_valid) ? `FUE_ERR_FW : 8'h00;
              if (s_r.tgt != `FUE_TGT_SERIAL && s_r.tgt != `FUE_TGT_PARALLEL) begin
                s_nxt.err0 = `FUE_ERR_HDR;
              end
              if ({rd, s_r.len[7:0]} != `FUE_FIRST_LEN) begin
                s_nxt.err0 = s_nxt.err0 | `FUE_ERR_LEN_BAD;
              end
            end else if (s_r.pos == `FUE_POS_MIDDLE || s_r.pos == `FUE_POS_LAST) begin
              if (!s_r.in_xfer || s_r.xfer_tgt != (s_r.tgt == `FUE_TGT_SERIAL)) begin
                s_nxt.err0 = s_nxt.err0 | `FUE_ERR_SEQ;
              end
              if ({rd, s_r.len[7:0]} != `FUE_PAYLOAD_BYTES) begin
                s_nxt.err0 = s_nxt.err0 | `FUE_ERR_LEN_BAD;
              end
            end else begin
              s_nxt.err0 = s_nxt.err0 | `FUE_ERR_SEQ;
            end
          end else if (s_r.grp == `FUE_FG_ERASE) begin
            s_nxt.cmd = FUE_CMD_ERASE;
            s_nxt.err0 = 8'h00;
            s_nxt.err1 = 8'h00;
            s_nxt.crc = 16'h0000;
            s_nxt.npkt = 32'h0000_0000;
            // Erase is one packet with fixed selector and length
            if (s_r.tgt != `FUE_TGT_PERASE || s_r.pos != `FUE_POS_ONLY
                || {rd, s_r.len[7:0]} != `FUE_ERASE_LEN) begin
              s_nxt.err0 = `FUE_ERR_HDR;
            end
          end else begin
            s_nxt.err0 = s_nxt.err0 | `FUE_ERR_HDR;
          end
          s_nxt.st = ({rd, s_r.len[7:0]} == 16'h0000) ? FUE_CSUM : FUE_PAY;
        end
      end
      FUE_PAY: begin
        if (take) begin
          s_nxt.sum = s_r.sum + rd;
          s_nxt.cnt = s_r.cnt + 16'h0001;
          if (s_r.cmd == FUE_CMD_ERASE) begin
            // Begin then end offset, each LSB first
            if (s_r.cnt < 16'h0004) begin
              s_nxt.ebeg = {rd, s_r.ebeg[31:8]};
            end else begin
              s_nxt.eend = {rd, s_r.eend[31:8]};
            end
          end else if (s_r.cmd == FUE_CMD_WRITE) begin
            if (s_r.pos == `FUE_POS_FIRST && s_r.cnt < 16'h0004) begin
              s_nxt.addr = {rd, s_r.addr[31:8]};
            end else if (s_r.err0 == 8'h00 && s_r.err1 == 8'h00) begin
              // Only clean data reaches the flash and the CRC
              s_nxt.wr = 1'b1;
              s_nxt.wdata = rd;
              s_nxt.crc = crc16_byte(s_r.crc, rd);
            end
          end
          if (s_r.cnt + 16'h0001 == s_r.len) begin
            s_nxt.st = FUE_CSUM;
          end
        end
      end
      FUE_CSUM: begin
        if (take && !s_r.wr) begin
          if (rd != s_r.sum) begin
            s_nxt.err0 = s_r.err0 | `FUE_ERR_CSUM;
          end
          s_nxt.npkt = s_r.npkt + 32'h0000_0001;
          s_nxt.hidx = 2'h0;
          s_nxt.ridx = 4'h0;
          s_nxt.rsum = 8'h00;
          if (s_r.cmd == FUE_CMD_ERASE && s_r.err0 == 8'h00 && rd == s_r.sum) begin
            s_nxt.estart = 1'b1;
            s_nxt.ewait = 1'b1;
            s_nxt.st = FUE_EXEC;
          end else if (s_r.cmd == FUE_CMD_WRITE && s_r.pos != `FUE_POS_LAST
                       && s_r.in_xfer) begin
            s_nxt.st = FUE_HDR;
          end else begin
            s_nxt.in_xfer = 1'b0;
            s_nxt.st = FUE_RESP;
          end
        end
      end
      FUE_EXEC: begin
        // Busy stays high until the erase engine reports completion
        if (erase_done) begin
          s_nxt.ewait = 1'b0;
          s_nxt.st = FUE_RESP;
        end
      end
      FUE_RESP: begin
        if (!s_r.txv || tx_ready) begin
          s_nxt.txv = 1'b1;
          s_nxt.txd = rbyte;
          s_nxt.ridx = s_r.ridx + 4'h1;
          if (s_r.ridx >= 4'h4) begin
            s_nxt.rsum = s_r.rsum + rbyte;
          end
          // Checksum slot is the last one; only then hand over to the drain state
          if (s_r.ridx == 4'hF) begin
            s_nxt.st = FUE_SKIP;
          end
          if (s_r.ridx == 4'h6 + rlen[3:0] - 4'h1) begin
            s_nxt.ridx = 4'hF;
          end
        end
      end
      default: begin
        // Drain the last response byte, then idle
        if (!s_r.txv || tx_ready) begin
          s_nxt.txv = 1'b0;
          s_nxt.st = FUE_HDR;
        end
      end
    endcase
    if (s_r.st != FUE_RESP && s_r.st != FUE_SKIP && tx_ready) begin
      s_nxt.txv = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from state flops; busy is decoded from the state and the pending write
  assign tx_data = s_r.txd;
  assign tx_valid = s_r.txv;
  assign busy = (s_r.st == FUE_EXEC) || (s_r.st == FUE_RESP) || s_r.wr;
  assign flash_addr = s_r.addr;
  assign flash_wdata = s_r.wdata;
  assign flash_wr = s_r.wr;
  assign flash_serial = s_r.serial;
  assign erase_begin = s_r.ebeg;
  assign erase_end = s_r.eend;
  assign erase_start = s_r.estart;
endmodule

// ==== core/fue_params.svh ====
`ifndef FUE_PARAMS_SVH
`define FUE_PARAMS_SVH
`define FUE_OP_WRITE 8'h02
`define FUE_OP_WRITE_RESPONSE_OPCODE 8'h03
`define FUE_FG_UPDATE 8'h06
`define FUE_FG_ERASE 8'h07
`define FUE_TGT_SERIAL 8'h01
`define FUE_TGT_PARALLEL 8'h00
`define FUE_TGT_PERASE 8'h10
`define FUE_POS_ONLY 8'h00
`define FUE_POS_FIRST 8'h01
`define FUE_POS_MIDDLE 8'h02
`define FUE_POS_LAST 8'h04
`define FUE_PAYLOAD_BYTES 16'h0100
`define FUE_FIRST_LEN 16'h0104
`define FUE_ERASE_LEN 16'h0008
`define FUE_RESP_LEN 8'h08
`define FUE_ERR_LEN 8'h02
`define FUE_ERR_CSUM 8'h01
`define FUE_ERR_HDR 8'h02
`define FUE_ERR_LEN_BAD 8'h04
`define FUE_ERR_SEQ 8'h08
`define FUE_ERR_FW 8'h01
`define FUE_CRC_INIT 16'hFFFF
`define FUE_CRC_POLY 16'h1021
`define FUE_ADDR_BYTES 3'h4
`endif

// ==== core/fue_pkg.sv ====
package fue_pkg;
  typedef enum logic [3:0] {
    FUE_HDR = 4'h0,
    FUE_LENL = 4'h1,
    FUE_LENH = 4'h3,
    FUE_PAY = 4'h2,
    FUE_CSUM = 4'h6,
    FUE_EXEC = 4'h7,
    FUE_RESP = 4'h5,
    FUE_SKIP = 4'h4
  } fue_state_type;
  typedef enum logic [1:0] {
    FUE_CMD_NONE = 2'h0,
    FUE_CMD_WRITE = 2'h1,
    FUE_CMD_ERASE = 2'h2
  } fue_cmd_type;
endpackage

// ==== verification/flash_update_erase_packets_tb.sv ====
`timescale 1ns/100ps
`include "fue_params.svh"
// Sends command packets, reads replies with stalls, checks flash traffic
module flash_update_erase_packets_tb;
  logic clk = 1'b0;
  logic reset_n, rx_valid, rx_ready, tx_valid, tx_ready, fw_valid, busy;
  logic [7:0] rx_data, tx_data, flash_wdata;
  logic [31:0] flash_addr, erase_begin, erase_end, erb, ere;
  logic flash_wr, flash_ready, flash_serial, erase_start, erase_done;
  int failures = 0;
  int n_checks = 0;
  logic [7:0] rsp[$];
  logic [7:0] pay[$];
  logic [7:0] dq[$];
  logic [40:0] wl[$];
  always #4 clk = ~clk;
  fue_core fue_core_inst (.clk(clk), .reset_n(reset_n), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
    .tx_ready(tx_ready), .fw_valid(fw_valid), .busy(busy), .flash_addr(flash_addr),
    .flash_wdata(flash_wdata), .flash_wr(flash_wr), .flash_ready(flash_ready),
    .flash_serial(flash_serial), .erase_begin(erase_begin), .erase_end(erase_end),
    .erase_start(erase_start), .erase_done(erase_done));
  fue_flash_model fue_flash_model_inst (.clk(clk), .erase_start(erase_start),
    .flash_ready(flash_ready), .erase_done(erase_done));
  // Reader stalls at random; a stalled byte must wait, not vanish
  always @(negedge clk) tx_ready <= ($urandom % 3) != 0;
  // Log taken reply bytes, accepted flash writes and erase requests
  always @(posedge clk) begin
    if (tx_valid === 1'b1 && tx_ready === 1'b1) rsp.push_back(tx_data);
    if (flash_wr === 1'b1 && flash_ready === 1'b1) wl.push_back({flash_serial, flash_addr, flash_wdata});
    if (erase_start === 1'b1) begin
      erb = erase_begin;
      ere = erase_end;
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkw(input logic [40:0] got, input logic [40:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] b);
    c ^= {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? {c[14:0], 1'b0} ^ `FUE_CRC_POLY : {c[14:0], 1'b0};
    return c;
  endfunction
  // One byte, held until the core has room; valid is left up for the next
  task automatic put(input logic [7:0] b);
    int n;
    n = 0;
    rx_data = b;
    rx_valid = 1'b1;
    while (rx_ready !== 1'b1 && n < 3000) begin
      @(negedge clk);
      n++;
    end
    chkw(41'(n >= 3000), 41'h0);
    @(negedge clk);
  endtask
  task automatic send_pkt(input logic [7:0] grp, tgt, pos, input logic bad);
    logic [7:0] s;
    logic [15:0] len;
    len = 16'(pay.size());
    s = len[7:0] + len[15:8] + {7'h0, bad};
    foreach (pay[i]) s += pay[i];
    put(`FUE_OP_WRITE);
    put(grp);
    put(tgt);
    put(pos);
    put(len[7:0]);
    put(len[15:8]);
    foreach (pay[i]) put(pay[i]);
    put(s);
    rx_valid = 1'b0;
  endtask
  task automatic get_rsp(input logic [7:0] grp, e0, e1, input logic [15:0] crc,
                         input logic [31:0] cnt, input bit full);
    logic [7:0] e[$];
    logic [7:0] s;
    int n;
    e = '{8'h03, grp, 8'h00, 8'h00, (e0 != 8'h00) ? 8'h02 : 8'h08, 8'h00, e0, e1};
    if (e0 == 8'h00) e = {e, crc[7:0], crc[15:8], cnt[7:0], cnt[15:8], cnt[23:16], cnt[31:24]};
    s = 8'h00;
    for (int i = 4; i < e.size(); i++) s += e[i];
    e.push_back(s);
    n = 0;
    // Wait for every byte the core sends, so none spills into the next test
    while ((rsp.size() < e.size() || busy !== 1'b0) && n < 5000) begin
      @(negedge clk);
      n++;
    end
    chkw(41'(n >= 5000), 41'h0);
    if (!full) e = e[0:7];
    foreach (e[i]) chk8(rsp.size() > i ? rsp[i] : 8'hXX, e[i]);
    rsp.delete();
  endtask
  task automatic update(input logic [7:0] tgt, input logic [31:0] a, input int np,
                        input logic [7:0] e0, e1);
    logic [15:0] crc;
    int pad;
    crc = `FUE_CRC_INIT;
    pad = 128 + $urandom % 128;
    dq.delete();
    wl.delete();
    for (int p = 0; p < np; p++) begin
      pay = {};
      if (p == 0) pay = {a[7:0], a[15:8], a[23:16], a[31:24]};
      for (int i = 0; i < 256; i++) begin
        // A short last parallel chunk is filled up with all-ones
        pay.push_back((tgt == `FUE_TGT_PARALLEL && p == np - 1 && i >= pad) ? 8'hFF
                      : 8'($urandom));
        dq.push_back(pay[$]);
        crc = crc16(crc, pay[$]);
      end
      send_pkt(`FUE_FG_UPDATE, tgt, p == 0 ? `FUE_POS_FIRST : p == np - 1 ? `FUE_POS_LAST :
               `FUE_POS_MIDDLE, e0 != 8'h00 && p == np - 1);
      repeat (8) @(negedge clk);
      if (p < np - 1) chkw(41'(rsp.size()), 41'h0);
    end
    // Without firmware nothing is written, so the CRC stays at its seed
    if (e1 != 8'h00) crc = `FUE_CRC_INIT;
    get_rsp(`FUE_FG_UPDATE, e0, e1, crc, 32'(np), 1'b1);
    if (e1 != 8'h00) chkw(41'(wl.size()), 41'h0);
    if (e0 == 8'h00 && e1 == 8'h00) begin
      chkw(41'(wl.size()), 41'(dq.size()));
      foreach (wl[i]) chkw(wl[i], {tgt[0], a + 32'(i), dq[i]});
    end
  endtask
  // One erase packet; the reply is read only once busy has dropped
  task automatic erase(input logic [31:0] b, input logic [31:0] e);
    pay = {b[7:0], b[15:8], b[23:16], b[31:24], e[7:0], e[15:8], e[23:16], e[31:24]};
    send_pkt(`FUE_FG_ERASE, `FUE_TGT_PERASE, `FUE_POS_ONLY, 1'b0);
    get_rsp(`FUE_FG_ERASE, 8'h00, 8'h00, 16'h0, 32'h1, 1);
    chkw(41'(erb), 41'(b));
    chkw(41'(ere), 41'(e));
  endtask
  task automatic wrap_up;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Watchdog, well beyond the expected run of a few thousand cycles
  initial begin
    #400000;
    failures++;
    wrap_up;
  end
  initial begin
    logic [31:0] a0;
    void'($urandom(32'hD6D2));
    reset_n = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
    fw_valid = 1'b1;
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    // Region from offset zero to the end of the parallel image is erased first
    a0 = $urandom & 32'h00FF_FFFF;
    erase(32'h0000_0000, a0 + 32'h0000_02FF);
    $display("first erase done");
    update(`FUE_TGT_PARALLEL, a0, 3, 8'h00, 8'h00);
    $display("parallel update done");
    // Serial image cut to two packets to keep the run short; the split is unchanged
    update(`FUE_TGT_SERIAL, 32'h00300000, 2, 8'h00, 8'h00);
    $display("serial update done");
    update(`FUE_TGT_PARALLEL, $urandom, 2, `FUE_ERR_CSUM, 8'h00);
    $display("bad checksum done");
    pay = {};
    for (int i = 0; i < 256; i++) pay.push_back(8'($urandom));
    send_pkt(`FUE_FG_UPDATE, `FUE_TGT_PARALLEL, `FUE_POS_MIDDLE, 1'b0);
    get_rsp(`FUE_FG_UPDATE, `FUE_ERR_SEQ, 8'h00, 16'h0, 32'h0, 1);
    $display("out of sequence done");
    fw_valid = 1'b0;
    update(`FUE_TGT_SERIAL, 32'h00300000, 2, 8'h00, `FUE_ERR_FW);
    fw_valid = 1'b1;
    $display("no firmware done");
    erase($urandom, $urandom);
    $display("erase done");
    wrap_up;
  end
endmodule

// ==== verification/fue_core_monitor.sv ====
`timescale 1ns/100ps
// Port-level checks on the update core
module fue_core_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  input wire logic tx_ready,
  input wire logic fw_valid,
  input wire logic busy,
  input wire logic [31:0] flash_addr,
  input wire logic [7:0] flash_wdata,
  input wire logic flash_wr,
  input wire logic flash_ready,
  input wire logic flash_serial,
  input wire logic [31:0] erase_begin,
  input wire logic [31:0] erase_end,
  input wire logic erase_start,
  input wire logic erase_done
);
  logic wait_r;
  logic wait_nxt;
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Erase window, open from the start pulse until the flash reports done
  always_comb begin
    wait_nxt = erase_start | (wait_r & ~erase_done);
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wait_r <= 1'b0;
    end else begin
      wait_r <= wait_nxt;
    end
  end
  sequence s_erase_end;
    wait_r && erase_done;
  endsequence
  sequence s_reply_op;
    tx_valid && tx_data == 8'h03;
  endsequence
  a_wr_hold: assert property (
    flash_wr && !flash_ready |=> flash_wr && $stable(flash_addr) && $stable(flash_wdata))
    else $error("stalled flash write changed");
  a_wr_addr_step: assert property (
    flash_wr && flash_ready |=> flash_addr == $past(flash_addr) + 32'h1)
    else $error("flash address did not step by one");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("reply byte dropped while stalled");
  a_erase_one_pulse: assert property (
    erase_start |=> !erase_start) else $error("erase start longer than one cycle");
  a_erase_busy: assert property (
    wait_r |-> busy) else $error("busy low while erasing");
  a_erase_quiet: assert property (
    wait_r |-> !tx_valid) else $error("reply before erase finished");
  a_erase_reply: assert property (
    s_erase_end |-> ##[1:2] s_reply_op) else $error("no reply after erase done");
  a_fw_gate: assert property (
    flash_wr && flash_serial |-> fw_valid) else $error("serial write without firmware");
endmodule
bind fue_core fue_core_monitor fue_core_monitor_inst (.clk(clk), .reset_n(reset_n),
  .rx_data(rx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data),
  .tx_valid(tx_valid), .tx_ready(tx_ready), .fw_valid(fw_valid), .busy(busy),
  .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_wr(flash_wr),
  .flash_ready(flash_ready), .flash_serial(flash_serial), .erase_begin(erase_begin),
  .erase_end(erase_end), .erase_start(erase_start), .erase_done(erase_done));

// ==== verification/fue_flash_model.sv ====
`timescale 1ns/100ps
// Flash side: takes writes with random stalls, finishes erases after a varying time
module fue_flash_model (
  input wire logic clk,
  input wire logic erase_start,
  output logic flash_ready,
  output logic erase_done
);
  int cnt = 0;
  initial begin
    flash_ready = 1'b0;
    erase_done = 1'b0;
  end
  // Stalls back up the core's input buffer so refusal is exercised
  always @(negedge clk) begin
    flash_ready <= ($urandom % 4) != 0;
    erase_done <= 1'b0;
    if (erase_start === 1'b1 && cnt == 0) begin
      cnt <= 10 + $urandom % 30;
    end else if (cnt == 1) begin
      cnt <= 0;
      erase_done <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule
